// [rcs_decode.sv]
// opcode decoder: classifies one 14-bit instruction word
// assumes the word is stable for the whole instruction cycle
`default_nettype none
module rcs_decode
    import rcs_pkg::*;
(
    input  wire logic [OPC_W-1:0] opcode,
    output decoded_t              dec
);
    always_comb
    begin
        dec.addr   = opcode[FADDR_W-1:0];
        dec.dest_f = opcode[D_BIT];
        if (opcode == OPC_POWERDOWN)
            dec.kind = OP_SLEEP;
        else if (opcode[13:8] == OPC_RL_PREFIX)
            dec.kind = OP_RL;
        else if (opcode[13:8] == OPC_RR_PREFIX)
            dec.kind = OP_RR;
        else
            dec.kind = OP_NONE;
    end
endmodule
`default_nettype wire

// [rcs_exec.sv]
// execution unit for rotate-through-carry and power-down instructions
// assumes file register read data answers combinationally to FILE_RADDR
// What this block does
// RULE1 - rotate left: bits move up, carry enters bit 0, old msb becomes carry
// RULE2 - destination bit 0 writes working register, 1 writes the file register back
// RULE3 - one cycle of four phases: decode, read, process, write
// RULE4 - power-down recognised by its fixed 14-bit opcode, no operands
// RULE5 - power-down clears the power-down flag
// RULE6 - power-down sets the timeout flag
// RULE7 - power-down clears watchdog counter and its prescaler
// RULE8 - after power-down oscillator halts and execution stops
// RULE9 - rotate right: bits move down, carry enters msb, old bit 0 becomes carry
`default_nettype none
module rcs_exec
    import rcs_pkg::*;
(
    input  wire logic                 CLK_SYS,
    input  wire logic                 ARST_N,
    input  wire logic [OPC_W-1:0]     OPCODE,
    input  wire logic [DATA_W-1:0]    FILE_RDATA,
    output logic      [FADDR_W-1:0]   FILE_RADDR,
    output rcs_pkg::file_wr_t         FILE_WR,
    output logic      [DATA_W-1:0]    W_REG,
    output logic                      CARRY,
    output logic                      TIMEOUT_FLAG,
    output logic                      POWERDOWN_FLAG,
    output logic                      WDT_CLEAR,
    output logic                      OSC_HALT,
    output logic                      PHASE_Q1
);
    import rcs_pkg::*;

    decoded_t          dec;
    decoded_t          dec_r;
    logic [1:0]        phase_r;
    logic [DATA_W-1:0] data_r;
    logic [DATA_W-1:0] res_r;
    logic              cy_r;
    logic              halt_r;

    rcs_decode u_dec
    (
        .opcode (OPCODE),
        .dec    (dec)
    );

    // phase counter freezes once the oscillator is halted
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            phase_r <= PHASE_RST;
        else if (!halt_r)
            phase_r <= phase_r + 2'h1; // RULE3
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            PHASE_Q1 <= 1'b1;
        else
            PHASE_Q1 <= !halt_r && phase_r == 2'h3;
    end

    // decode latched in the first phase, held for the rest of the cycle
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            dec_r <= '{kind: OP_NONE, addr: 7'h00, dest_f: 1'b0};
        else if (!halt_r && phase_r == 2'h0)
            dec_r <= dec; // RULE3 RULE4
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            FILE_RADDR <= 7'h00;
        else if (!halt_r && phase_r == 2'h0)
            FILE_RADDR <= dec.addr;
    end

    // read in second phase
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            data_r <= 8'h00;
        else if (!halt_r && phase_r == 2'h1)
            data_r <= FILE_RDATA; // RULE3
    end

    // process in third phase; carry is staged so status changes only at write
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            res_r <= 8'h00;
            cy_r  <= CARRY_RST;
        end
        else if (!halt_r && phase_r == 2'h2)
        begin
            if (dec_r.kind == OP_RL)
            begin
                res_r <= {data_r[6:0], CARRY}; // RULE1
                cy_r  <= data_r[7];            // RULE1
            end
            else
            begin
                res_r <= {CARRY, data_r[7:1]}; // RULE9
                cy_r  <= data_r[0];            // RULE9
            end
        end
    end

    logic rot_wr;
    assign rot_wr = !halt_r && phase_r == 2'h3
                    && (dec_r.kind == OP_RL || dec_r.kind == OP_RR);

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            W_REG <= W_RST;
        else if (rot_wr && !dec_r.dest_f)
            W_REG <= res_r; // RULE2
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            FILE_WR <= '{data: 8'h00, addr: 7'h00, we: 1'b0};
        else
        begin
            FILE_WR.we   <= rot_wr && dec_r.dest_f; // RULE2
            FILE_WR.data <= res_r;
            FILE_WR.addr <= dec_r.addr;
        end
    end

    // only carry changes among status bits on a rotate
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            CARRY <= CARRY_RST;
        else if (rot_wr)
            CARRY <= cy_r; // RULE9
    end

    logic sleep_go;
    assign sleep_go = !halt_r && phase_r == 2'h3 && dec_r.kind == OP_SLEEP;

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            TIMEOUT_FLAG   <= TIMEOUT_RST;
            POWERDOWN_FLAG <= POWERDOWN_RST;
        end
        else if (sleep_go)
        begin
            TIMEOUT_FLAG   <= 1'b1; // RULE6
            POWERDOWN_FLAG <= 1'b0; // RULE5
        end
    end

    // one pulse clears both watchdog counter and prescaler outside
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            WDT_CLEAR <= 1'b0;
        else
            WDT_CLEAR <= sleep_go; // RULE7
    end

    // wake-up is outside this block: only reset releases the halt
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            halt_r <= 1'b0;
        else if (sleep_go)
            halt_r <= 1'b1; // RULE8
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            OSC_HALT <= 1'b0;
        else if (sleep_go)
            OSC_HALT <= 1'b1; // RULE8
    end

    // assertions
    property p_rl_result;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (phase_r == 2'h2 && !halt_r && dec_r.kind == OP_RL)
        |=> res_r == {$past(data_r[6:0]), $past(CARRY)}
        ##1 CARRY == $past(data_r[7], 2);
    endproperty
    a_rl_result: assert property (p_rl_result) else $error("rotate left result wrong"); // RULE1
    property p_rr_carry;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (phase_r == 2'h2 && !halt_r && dec_r.kind == OP_RR) |=> ##1 CARRY == $past(data_r[0], 2);
    endproperty
    a_rr_carry: assert property (p_rr_carry) else $error("rotate right carry wrong"); // RULE9
    property p_dest_w;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        rot_wr && !dec_r.dest_f |=> W_REG == $past(res_r) && !FILE_WR.we;
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("w destination wrong"); // RULE2
    property p_dest_f;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        rot_wr && dec_r.dest_f |=> FILE_WR.we && FILE_WR.data == $past(res_r) && $stable(W_REG);
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("file destination wrong"); // RULE2
    property p_four_phase;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        // second step demands a real phase advance, so a reset release edge cannot start it
        !halt_r && phase_r == 2'h0 && dec.kind == OP_RL ##1 phase_r == 2'h1 |-> ##2 rot_wr;
    endproperty
    a_four_phase: assert property (p_four_phase) else $error("write not in fourth phase"); // RULE3
    property p_sleep_decode;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        dec.kind == OP_SLEEP |-> OPCODE == OPC_POWERDOWN;
    endproperty
    a_sleep_decode: assert property (p_sleep_decode) else $error("bad sleep decode"); // RULE4
    property p_pd_clear;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        sleep_go |=> !POWERDOWN_FLAG [*3];
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("power-down flag not cleared"); // RULE5
    property p_to_set;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        sleep_go |=> TIMEOUT_FLAG;
    endproperty
    a_to_set: assert property (p_to_set) else $error("timeout flag not set"); // RULE6
    property p_wdt;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        sleep_go |=> WDT_CLEAR ##1 !WDT_CLEAR;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clear pulse wrong"); // RULE7
    property p_halt;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        OSC_HALT |=> $stable(phase_r) && !FILE_WR.we && $stable(W_REG);
    endproperty
    a_halt: assert property (p_halt) else $error("execution after halt"); // RULE8
    c_rl: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) rot_wr && dec_r.kind == OP_RL);
    c_rr_f: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
        rot_wr && dec_r.kind == OP_RR && dec_r.dest_f);
    c_sleep: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) sleep_go);
endmodule
`default_nettype wire

// [rcs_pkg.sv]
// package for the rotate-through-carry and power-down execution block
// assumes a single 100 MHz clock and a core that presents one opcode per instruction cycle
`default_nettype none
package rcs_pkg;
    localparam int          DATA_W          = 8;
    localparam int          OPC_W           = 14;
    localparam int          FADDR_W         = 7;
    localparam int          PHASES          = 4;
    localparam logic [13:0] OPC_POWERDOWN   = 14'h0063;
    localparam logic [5:0]  OPC_RL_PREFIX   = 6'h0D;
    localparam logic [5:0]  OPC_RR_PREFIX   = 6'h0C;
    localparam int          D_BIT           = 7;
    localparam logic        TIMEOUT_RST     = 1'b1;
    localparam logic        POWERDOWN_RST   = 1'b1;
    localparam logic        CARRY_RST       = 1'b0;
    localparam logic [7:0]  W_RST           = 8'h00;
    localparam logic [1:0]  PHASE_RST       = 2'h0;

    typedef enum logic [1:0] {OP_NONE, OP_RL, OP_RR, OP_SLEEP} op_kind_t;

    typedef struct packed {
        logic [7:0] data;
        logic [6:0] addr;
        logic       we;
    } file_wr_t;

    typedef struct packed {
        op_kind_t   kind;
        logic [6:0] addr;
        logic       dest_f;
    } decoded_t;
endpackage
`default_nettype wire

// [rotate_carry_and_sleep_exec_tb.sv]
// self-checking bench for the rotate-through-carry and power-down execution unit
// assumes rcs_pkg and rcs_exec are compiled first; one instruction every eight cycles, an idle instruction cycle before each
`default_nettype none
module rotate_carry_and_sleep_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcs_pkg::*;

    logic              CLK_SYS;
    logic              ARST_N;
    logic [13:0]       OPCODE;
    logic [7:0]        FILE_RDATA;
    logic [6:0]        FILE_RADDR;
    file_wr_t          FILE_WR;
    logic [7:0]        W_REG;
    logic              CARRY;
    logic              TIMEOUT_FLAG;
    logic              POWERDOWN_FLAG;
    logic              WDT_CLEAR;
    logic              OSC_HALT;
    logic              PHASE_Q1;
    int                fail_count = 0;
    int                cmp_count  = 0;

    rcs_exec DUT (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .OPCODE(OPCODE),
        .FILE_RDATA(FILE_RDATA), .FILE_RADDR(FILE_RADDR), .FILE_WR(FILE_WR),
        .W_REG(W_REG), .CARRY(CARRY), .TIMEOUT_FLAG(TIMEOUT_FLAG),
        .POWERDOWN_FLAG(POWERDOWN_FLAG), .WDT_CLEAR(WDT_CLEAR),
        .OSC_HALT(OSC_HALT), .PHASE_Q1(PHASE_Q1));

    initial CLK_SYS = 1'b0;
    always #5 CLK_SYS = ~CLK_SYS;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // called at a falling edge ahead of a phase-0 edge with an idle opcode;
    // stimulus moves only on rising edges, so one no-op cycle runs first
    task automatic run_op(input logic [13:0] opc, input logic [7:0] rd);
        @(posedge CLK_SYS);
        OPCODE     <= opc;
        FILE_RDATA <= rd;
        repeat (6) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk(FILE_WR.we, 1'h0);
        chk(WDT_CLEAR, 1'h0);
        @(posedge CLK_SYS);
        OPCODE <= 14'h0000;
        @(negedge CLK_SYS);
    endtask

    task automatic t_rotate_w();
        run_op({OPC_RL_PREFIX, 1'b0, 7'h10}, 8'hE6);
        chk(FILE_RADDR, 7'h10);
        chk(PHASE_Q1, 1'h1);
        chk({W_REG, CARRY}, {8'hCC, 1'b1});
        chk(FILE_WR.we, 1'h0);
        run_op({OPC_RR_PREFIX, 1'b0, 7'h22}, 8'hE6);
        chk({W_REG, CARRY}, {8'hF3, 1'b0});
    endtask

    task automatic t_rotate_f();
        run_op({OPC_RL_PREFIX, 1'b1, 7'h7F}, 8'h80);
        chk(FILE_WR, {8'h00, 7'h7F, 1'b1});
        chk({W_REG, CARRY}, {8'hF3, 1'b1});
        run_op({OPC_RR_PREFIX, 1'b1, 7'h00}, 8'h01);
        chk(FILE_WR, {8'h80, 7'h00, 1'b1});
        chk({W_REG, CARRY}, {8'hF3, 1'b1});
    endtask

    task automatic t_unknown();
        run_op(14'h0064, 8'h55);
        chk({W_REG, CARRY, POWERDOWN_FLAG, OSC_HALT}, {8'hF3, 3'b110});
        run_op(14'h0E10, 8'h55);
        chk({W_REG, CARRY, FILE_WR.we}, {8'hF3, 2'b10});
    endtask

    task automatic t_sleep();
        run_op(OPC_POWERDOWN, 8'h00);
        chk(POWERDOWN_FLAG, 1'h0);
        chk(TIMEOUT_FLAG, 1'h1);
        chk(WDT_CLEAR, 1'h1);
        chk(OSC_HALT, 1'h1);
        @(negedge CLK_SYS);
        chk(WDT_CLEAR, 1'h0);
        run_op({OPC_RL_PREFIX, 1'b0, 7'h01}, 8'h00);
        chk({W_REG, CARRY, OSC_HALT, PHASE_Q1}, {8'hF3, 3'b110});
    endtask

    // a reset in mid-run must lift the halt and let execution resume
    task automatic t_rereset();
        @(posedge CLK_SYS);
        ARST_N <= 1'b0;
        @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        @(negedge CLK_SYS);
        chk({W_REG, POWERDOWN_FLAG, OSC_HALT}, {8'h00, 2'b10});
        run_op({OPC_RL_PREFIX, 1'b0, 7'h05}, 8'h81);
        chk({W_REG, CARRY}, {8'h02, 1'b1});
    endtask

    initial
    begin
        ARST_N     = 1'b0;
        OPCODE     = 14'h0000;
        FILE_RDATA = 8'h00;
        repeat (2) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        @(negedge CLK_SYS);
        chk({W_REG, CARRY, TIMEOUT_FLAG, POWERDOWN_FLAG}, {8'h00, 3'b011});
        t_rotate_w();
        t_rotate_f();
        t_unknown();
        t_sleep();
        t_rereset();
        give_verdict();
    end

    // about 80 cycles of work; a hang is cut well beyond that
    initial
    begin
        repeat (1000) @(posedge CLK_SYS);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
